// *** shared/ubfi_pkg.sv ***
// Constants and types for the UART buffer, FIFO and interrupt block
package ubfi_pkg;
    // Register indices; byte address is four times the index
    localparam logic [2:0] IDX_DATA = 3'h0;
    localparam logic [2:0] IDX_IER  = 3'h1;
    localparam logic [2:0] IDX_IIR  = 3'h2;
    localparam logic [2:0] IDX_LCR  = 3'h3;
    localparam logic [2:0] IDX_LSR  = 3'h5;
    localparam logic [2:0] IDX_MSR  = 3'h6;
    localparam int         IDX_LSB  = 2;
    localparam int         IDX_MSB  = 4;
    // Field positions
    localparam int IER_RDA  = 0;
    localparam int IER_THRE = 1;
    localparam int IER_RLS  = 2;
    localparam int IER_MS   = 3;
    localparam int FCR_EN   = 0;
    localparam int FCR_RXCL = 1;
    localparam int FCR_TXCL = 2;
    localparam int FCR_TRLO = 6;
    localparam int FCR_TRHI = 7;
    localparam int LCR_DLS  = 7;
    localparam logic [7:0] IER_MASK = 8'h0F;
    // Identification codes, bits 3:0
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [3:0] IID_RLS  = 4'h6;
    localparam logic [3:0] IID_RDA  = 4'h4;
    localparam logic [3:0] IID_CTO  = 4'hC;
    localparam logic [3:0] IID_THRE = 4'h2;
    localparam logic [3:0] IID_MS   = 4'h0;
    localparam logic [1:0] IIR_FIFO = 2'h3;
    // Queue sizes and receive trigger levels
    localparam logic [4:0] DEPTH_FIFO = 5'h10;
    localparam logic [4:0] DEPTH_HOLD = 5'h01;
    localparam logic [4:0] TRIG_1     = 5'h01;
    localparam logic [4:0] TRIG_4     = 5'h04;
    localparam logic [4:0] TRIG_8     = 5'h08;
    localparam logic [4:0] TRIG_14    = 5'h0E;
    // Character framing and timeout, in bit ticks
    localparam logic [2:0] DATA_LAST     = 3'h7;
    localparam int         CHAR_BITS     = 10;
    localparam int         TIMEOUT_CHARS = 4;
    localparam logic [5:0] TIMEOUT_TICKS =
        6'(CHAR_BITS * TIMEOUT_CHARS);
    localparam logic [1:0] HTRANS_NSEQ = 2'h2;
    typedef enum logic [2:0] {
        SER_IDLE = 3'h1,
        SER_DATA = 3'h2,
        SER_STOP = 3'h4
    } ubfi_ser_t;
endpackage : ubfi_pkg

// *** rtl/ubfi_uart_core.sv ***
// UART holding registers, FIFOs and prioritised interrupt identification
`timescale 1ns/1ps
`default_nettype none
module ubfi_uart_core
    import ubfi_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Serial line and bit rate
    input  wire logic        baudTick,
    input  wire logic        rxd,
    output logic             txd,
    // Line and modem status section
    input  wire logic [7:0]  lineStatus,
    input  wire logic [7:0]  modemStatus,
    input  wire logic        lineErrEvt,
    input  wire logic        modemChgEvt,
    output logic             lineStatRd,
    output logic             modemStatRd,
    output logic [7:0]       lineCtrl,
    output logic [15:0]      divisor,
    // Interrupt
    output logic             irq
);
    function automatic logic [4:0] cntNext(input logic [4:0] c,
                                           input logic inc,
                                           input logic dec);
        cntNext = c + {4'h0, inc} - {4'h0, dec};
    endfunction : cntNext

    function automatic logic [3:0] ptrInc(input logic [3:0] p);
        ptrInc = p + 4'h1;
    endfunction : ptrInc

    logic [7:0]  ier_r;
    logic        fifoEn_r;
    logic [4:0]  trig_r;
    logic [7:0]  lcr_r;
    logic [15:0] div_r;
    logic        wrPend_r;
    logic [2:0]  wrIdx_r;
    logic [7:0]  rxMem [16];
    logic [3:0]  rxWp_r, rxRp_r;
    logic [4:0]  rxCnt_r;
    logic [7:0]  txMem [16];
    logic [3:0]  txWp_r, txRp_r;
    logic [4:0]  txCnt_r;
    ubfi_ser_t   rxSt_r, txSt_r;
    logic [7:0]  rxSh_r, txSh_r;
    logic [2:0]  rxBit_r, txBit_r;
    logic [5:0]  toCnt_r;
    logic        ctoPend_r, threPend_r, rlsPend_r, msPend_r;
    logic [31:0] hrdata_r;
    logic        txd_r, irq_r, lsRd_r, msRd_r;

    logic        rdAcc, wrAcc, dls, fcrWr, rxFlush, txFlush;
    logic [2:0]  aIdx;
    logic [7:0]  wByte, rdByte;
    logic        rbPop, thrPush, rxPush, txPop, threSet, ctoSet;
    logic [4:0]  cap;
    logic        rdaLvl, rlsOn, rdaOn, ctoOn, threOn, msOn, anyOn;
    logic [3:0]  iidNow;

    assign aIdx  = haddr[IDX_MSB:IDX_LSB];
    assign rdAcc = hsel && hready && (htrans == HTRANS_NSEQ) && !hwrite;
    assign wrAcc = hsel && hready && (htrans == HTRANS_NSEQ) && hwrite;
    assign wByte = hwdata[7:0];
    assign dls   = lcr_r[LCR_DLS];
    assign cap   = fifoEn_r ? DEPTH_FIFO : DEPTH_HOLD;
    assign fcrWr = wrPend_r && (wrIdx_r == IDX_IIR);
    // Mode change or disable empties both; bit 3 unused
    assign rxFlush = fcrWr && (!wByte[FCR_EN] || !fifoEn_r
                               || wByte[FCR_RXCL]);
    assign txFlush = fcrWr && (!wByte[FCR_EN] || !fifoEn_r
                               || wByte[FCR_TXCL]);
    assign rbPop   = rdAcc && (aIdx == IDX_DATA) && !dls
                     && (rxCnt_r != 5'h00);
    assign thrPush = wrPend_r && (wrIdx_r == IDX_DATA) && !dls
                     && (txCnt_r != cap);
    assign rxPush  = baudTick && (rxSt_r == SER_STOP) && !rxFlush
                     && (rxCnt_r != cap);
    assign txPop   = baudTick && (txSt_r == SER_IDLE) && !txFlush
                     && (txCnt_r != 5'h00);
    assign threSet = txPop && (txCnt_r == DEPTH_HOLD) && !thrPush;
    assign ctoSet  = baudTick && (toCnt_r == TIMEOUT_TICKS - 6'h01);

    // Interrupt sources and priority
    assign rdaLvl = fifoEn_r ? (rxCnt_r >= trig_r)
                             : (rxCnt_r != 5'h00);
    assign rlsOn  = rlsPend_r  && ier_r[IER_RLS];
    assign rdaOn  = rdaLvl     && ier_r[IER_RDA];
    assign ctoOn  = ctoPend_r  && ier_r[IER_RDA] && fifoEn_r;
    assign threOn = threPend_r && ier_r[IER_THRE];
    assign msOn   = msPend_r   && ier_r[IER_MS];
    assign anyOn  = rlsOn || rdaOn || ctoOn || threOn || msOn;
    always_comb begin
        if (rlsOn) iidNow = IID_RLS;
        else if (ctoOn) iidNow = IID_CTO;
        else if (rdaOn) iidNow = IID_RDA;
        else if (threOn) iidNow = IID_THRE;
        else if (msOn) iidNow = IID_MS;
        else iidNow = IID_NONE;
    end
    always_comb begin
        unique case (aIdx)
            IDX_DATA: rdByte = dls ? div_r[7:0] : rxMem[rxRp_r];
            IDX_IER:  rdByte = dls ? div_r[15:8] : ier_r;
            IDX_IIR:  rdByte = {(fifoEn_r ? IIR_FIFO : 2'h0),
                                2'h0, iidNow};
            IDX_LCR:  rdByte = lcr_r;
            IDX_LSR:  rdByte = lineStatus;
            IDX_MSR:  rdByte = modemStatus;
            default:  rdByte = 8'h00;
        endcase
    end
    // Read data is captured at the address phase, so it stays frozen
    always_ff @(posedge clk) begin
        if (srst) hrdata_r <= 32'h0000_0000;
        else if (rdAcc) hrdata_r <= {24'h00_0000, rdByte};
    end
    always_ff @(posedge clk) begin
        wrPend_r <= !srst && wrAcc;
        wrIdx_r  <= srst ? IDX_DATA : aIdx;
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            ier_r    <= 8'h00;
            fifoEn_r <= 1'b0;
            trig_r   <= TRIG_1;
            lcr_r    <= 8'h00;
            div_r    <= 16'h0000;
        end else if (wrPend_r) begin
            unique case (wrIdx_r)
                IDX_DATA: if (dls) div_r[7:0] <= wByte;
                IDX_IER: begin
                    if (dls) begin
                        div_r[15:8] <= wByte;
                    end else begin
                        ier_r <= wByte & IER_MASK;
                    end
                end
                IDX_IIR: begin
                    fifoEn_r <= wByte[FCR_EN];
                    if (wByte[FCR_EN]) begin
                        unique case (wByte[FCR_TRHI:FCR_TRLO])
                            2'h0: trig_r <= TRIG_1;
                            2'h1: trig_r <= TRIG_4;
                            2'h2: trig_r <= TRIG_8;
                            2'h3: trig_r <= TRIG_14;
                        endcase
                    end
                end
                IDX_LCR: lcr_r <= wByte;
                default: ;
            endcase
        end
    end

    // Receive queue
    always_ff @(posedge clk) begin
        if (srst || rxFlush) begin
            rxWp_r  <= 4'h0;
            rxRp_r  <= 4'h0;
            rxCnt_r <= 5'h00;
        end else begin
            if (rxPush) begin
                rxMem[rxWp_r] <= rxSh_r;
                rxWp_r        <= ptrInc(rxWp_r);
            end
            if (rbPop) begin
                rxRp_r <= ptrInc(rxRp_r);
            end
            rxCnt_r <= cntNext(rxCnt_r, rxPush, rbPop);
        end
    end

    // Transmit queue
    always_ff @(posedge clk) begin
        if (srst || txFlush) begin
            txWp_r  <= 4'h0;
            txRp_r  <= 4'h0;
            txCnt_r <= 5'h00;
        end else begin
            if (thrPush) begin
                txMem[txWp_r] <= wByte;
                txWp_r        <= ptrInc(txWp_r);
            end
            if (txPop) begin
                txRp_r <= ptrInc(txRp_r);
            end
            txCnt_r <= cntNext(txCnt_r, thrPush, txPop);
        end
    end

    // Receive shifter, one sample per bit tick, LSB first
    always_ff @(posedge clk) begin
        if (srst) begin
            rxSt_r  <= SER_IDLE;
            rxSh_r  <= 8'h00;
            rxBit_r <= 3'h0;
        end else if (baudTick) begin
            unique case (rxSt_r)
                SER_IDLE: begin
                    rxBit_r <= 3'h0;
                    if (!rxd) rxSt_r <= SER_DATA;
                end
                SER_DATA: begin
                    rxSh_r  <= {rxd, rxSh_r[7:1]};
                    rxBit_r <= rxBit_r + 3'h1;
                    if (rxBit_r == DATA_LAST) rxSt_r <= SER_STOP;
                end
                SER_STOP: rxSt_r <= SER_IDLE;
            endcase
        end
    end

    // Transmit shifter: start bit, eight data bits, stop bit
    always_ff @(posedge clk) begin
        if (srst) begin
            txSt_r  <= SER_IDLE;
            txSh_r  <= 8'h00;
            txBit_r <= 3'h0;
            txd_r   <= 1'b1;
        end else if (baudTick) begin
            unique case (txSt_r)
                SER_IDLE: begin
                    txBit_r <= 3'h0;
                    txd_r   <= !txPop;
                    if (txPop) begin
                        txSh_r <= txMem[txRp_r];
                        txSt_r <= SER_DATA;
                    end
                end
                SER_DATA: begin
                    txd_r   <= txSh_r[0];
                    txSh_r  <= {1'b0, txSh_r[7:1]};
                    txBit_r <= txBit_r + 3'h1;
                    if (txBit_r == DATA_LAST) txSt_r <= SER_STOP;
                end
                SER_STOP: begin
                    txd_r  <= 1'b1;
                    txSt_r <= SER_IDLE;
                end
            endcase
        end
    end

    // Character timeout counter
    always_ff @(posedge clk) begin
        if (srst || rxPush || rbPop || !fifoEn_r || rxCnt_r == 5'h00) begin
            toCnt_r <= 6'h00;
        end else if (baudTick && toCnt_r != TIMEOUT_TICKS) begin
            toCnt_r <= toCnt_r + 6'h01;
        end
    end

    // Pending flags; a set in the same cycle wins over a clear
    always_ff @(posedge clk) begin
        if (srst) begin
            ctoPend_r  <= 1'b0;
            threPend_r <= 1'b1;
            rlsPend_r  <= 1'b0;
            msPend_r   <= 1'b0;
        end else begin
            ctoPend_r <= ctoSet
                      || (ctoPend_r && !rbPop && !rxFlush);
            threPend_r <= threSet || (threPend_r && !thrPush
                      && !(rdAcc && aIdx == IDX_IIR
                           && iidNow == IID_THRE));
            rlsPend_r <= lineErrEvt
                      || (rlsPend_r && !(rdAcc && aIdx == IDX_LSR));
            msPend_r  <= modemChgEvt
                      || (msPend_r && !(rdAcc && aIdx == IDX_MSR));
        end
    end
    always_ff @(posedge clk) begin
        irq_r  <= !srst && anyOn;
        lsRd_r <= !srst && rdAcc && (aIdx == IDX_LSR);
        msRd_r <= !srst && rdAcc && (aIdx == IDX_MSR);
    end
    assign hrdata      = hrdata_r;
    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign txd         = txd_r;
    assign irq         = irq_r;
    assign lineStatRd  = lsRd_r;
    assign modemStatRd = msRd_r;
    assign lineCtrl    = lcr_r;
    assign divisor     = div_r;
    AST_IER_UPPER: assert property (@(posedge clk) disable iff (srst)
        wrPend_r && wrIdx_r == IDX_IER && !dls |=> ier_r[7:4] == 4'h0)
        else $error("enable upper bits not zero");
    AST_IRQ_OFF: assert property (@(posedge clk) disable iff (srst)
        ier_r[3:0] == 4'h0 [*2] |-> !irq_r && iidNow == IID_NONE)
        else $error("interrupt with all enables clear");
    AST_IIR_HIGH: assert property (@(posedge clk) disable iff (srst)
        rdAcc && aIdx == IDX_IIR |=> hrdata_r[5:4] == 2'h0
        && hrdata_r[7:6] == ($past(fifoEn_r) ? IIR_FIFO : 2'h0))
        else $error("identification high bits wrong");
    AST_IIR_BIT0: assert property (@(posedge clk) disable iff (srst)
        rdAcc && aIdx == IDX_IIR |=> hrdata_r[0] == !$past(anyOn))
        else $error("identification pending bit wrong");
    AST_FIFO_OFF: assert property (@(posedge clk) disable iff (srst)
        fcrWr && !wByte[FCR_EN] |=> !fifoEn_r && rxCnt_r == 5'h00
        && txCnt_r == 5'h00)
        else $error("disable did not empty queues");
    AST_RX_CLR: assert property (@(posedge clk) disable iff (srst)
        fcrWr && wByte[FCR_RXCL] && rxSt_r != SER_DATA
        |=> rxCnt_r == 5'h00 && $stable(rxSh_r))
        else $error("receive clear failed");
    AST_TX_CLR: assert property (@(posedge clk) disable iff (srst)
        fcrWr && wByte[FCR_TXCL] |=> txCnt_r == 5'h00)
        else $error("transmit clear failed");
    AST_RLS_TOP: assert property (@(posedge clk) disable iff (srst)
        rdAcc && aIdx == IDX_IIR && rlsOn |=> hrdata_r[3:0] == IID_RLS)
        else $error("line status not top priority");
    AST_TX_LOAD: assert property (@(posedge clk) disable iff (srst)
        txPop |-> txSt_r == SER_IDLE ##1 txSt_r == SER_DATA && !txd_r)
        else $error("transmit load while busy");
    AST_CTO_SET: assert property (@(posedge clk) disable iff (srst)
        $rose(ctoPend_r) |-> fifoEn_r && rxCnt_r != 5'h00)
        else $error("timeout without stored data");
    AST_THRE_CLR: assert property (@(posedge clk) disable iff (srst)
        thrPush && !threSet |=> !threPend_r)
        else $error("transmit empty not cleared by write");
    AST_IIR_HOLD: assert property (@(posedge clk) disable iff (srst)
        rdAcc && aIdx == IDX_IIR |=> hrdata_r[3:0] == $past(iidNow))
        else $error("identification changed during read");
endmodule : ubfi_uart_core
`default_nettype wire

// *** verif/ubfi_serial_peer.sv ***
// Serial peer model: bit-rate ticks, receive line driver, transmit monitor
`timescale 1ns/1ps
`default_nettype none
module ubfi_serial_peer (
    // Clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // Serial line
    input  wire logic txd,
    output var  logic baudTick,
    output var  logic rxd
);
    logic [3:0] phase;
    logic [3:0] bitCnt;
    logic [7:0] shiftR;
    logic [7:0] rxq[$];
    initial begin
        rxd      = 1'b1;
        baudTick = 1'b0;
        phase    = 4'h0;
    end
    // One tick every sixteen clocks
    always @(posedge clk) begin
        if (srst) begin
            phase    <= 4'h0;
            baudTick <= 1'b0;
        end else begin
            phase    <= phase + 4'h1;
            baudTick <= (phase == 4'hE);
        end
    end
    // Mid-bit sampling of the transmit line, start, eight data, stop
    always @(posedge clk) begin
        if (srst) begin
            bitCnt <= 4'h0;
        end else if (phase == 4'h7) begin
            if (bitCnt == 4'h0) begin
                if (txd === 1'b0) bitCnt <= 4'h1;
            end else if (bitCnt != 4'h9) begin
                shiftR <= {txd, shiftR[7:1]};
                bitCnt <= bitCnt + 4'h1;
            end else begin
                if (txd === 1'b1) rxq.push_back(shiftR);
                bitCnt <= 4'h0;
            end
        end
    end
    // Sends one frame, data least significant bit first
    task automatic send(input logic [7:0] b);
        logic [9:0] frame;
        int         k;
        frame = {1'b1, b, 1'b0};
        for (k = 0; k < 10; k++) begin
            @(posedge clk iff phase == 4'h7);
            rxd <= frame[k];
        end
    endtask : send
endmodule : ubfi_serial_peer
`default_nettype wire

// *** verif/test_uart_buffers_fifo_interrupts.sv ***
// Testbench: register traffic, serial frames and interrupt identification
`timescale 1ns/1ps
`default_nettype none
module test_uart_buffers_fifo_interrupts import ubfi_pkg::*;;
    logic        clk, srst, hsel, hwrite, hreadyout, hresp;
    logic        baudTick, rxd, txd, lineErrEvt, modemChgEvt;
    logic        lineStatRd, modemStatRd, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  lineStatus, modemStatus, lineCtrl;
    logic [15:0] divisor;
    logic [7:0]  trigTab [4];
    logic [1:0]  tsel;
    int          errTotal, nChecks, t, k;
    ubfi_uart_core ubfi_uart_core_inst (
        .clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .baudTick(baudTick), .rxd(rxd), .txd(txd), .lineStatus(lineStatus),
        .modemStatus(modemStatus), .lineErrEvt(lineErrEvt),
        .modemChgEvt(modemChgEvt), .lineStatRd(lineStatRd),
        .modemStatRd(modemStatRd), .lineCtrl(lineCtrl), .divisor(divisor),
        .irq(irq));
    ubfi_serial_peer ubfi_serial_peer_inst (
        .clk(clk), .srst(srst), .txd(txd), .baudTick(baudTick), .rxd(rxd));
    always #5 clk = ~clk;
    task automatic finishTest;
        $display("checks %0d mismatches %0d", nChecks, errTotal);
        if (errTotal == 0 && nChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finishTest
    task automatic fail(input string s);
        errTotal++;
        $display("BAD %0t %s", $time, s);
    endtask : fail
    task automatic chk(input logic [31:0] got, exp, input string s);
        nChecks++;
        if (got !== exp) fail($sformatf("%s got %h exp %h", s, got, exp));
    endtask : chk
    // Waits for an edge with the slave ready, bounded
    task automatic edgeReady;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail("bus stuck");
            finishTest();
        end
    endtask : edgeReady
    task automatic bus(input logic w, input logic [2:0] i,
                       input logic [7:0] d, output logic [31:0] q);
        htrans <= HTRANS_NSEQ;
        haddr  <= {27'h0, i, 2'h0};
        hwrite <= w;
        edgeReady();
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        edgeReady();
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [2:0] i, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, i, d, q);
    endtask : wr
    task automatic rdc(input logic [2:0] i, input logic [7:0] e, string s);
        logic [31:0] q;
        bus(1'b0, i, 8'h00, q);
        chk(q, {24'h0, e}, s);
    endtask : rdc
    task automatic irqIs(input logic e);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, {31'h0, e}, "irq");
    endtask : irqIs
    task automatic peerGot(input logic [7:0] e);
        for (k = 0; k < 4000; k++) begin
            if (ubfi_serial_peer_inst.rxq.size() > 0) break;
            @(posedge clk);
        end
        if (ubfi_serial_peer_inst.rxq.size() == 0) begin
            fail("no serial byte");
            finishTest();
        end else begin
            chk({24'h0, ubfi_serial_peer_inst.rxq.pop_front()}, {24'h0, e},
                "tx");
        end
    endtask : peerGot
    task automatic txStarted;
        for (k = 0; k < 100 && txd !== 1'b0; k++) @(posedge clk);
        if (txd !== 1'b0) fail("no start bit");
    endtask : txStarted
    task automatic recv(input logic [7:0] b);
        ubfi_serial_peer_inst.send(b);
        repeat (20) @(posedge clk);
    endtask : recv
    initial begin
        clk = 1'b0; srst = 1'b1; hsel = 1'b1; haddr = '0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = '0; lineStatus = 8'h5A;
        modemStatus = 8'h3C; lineErrEvt = 1'b0; modemChgEvt = 1'b0;
        errTotal = 0; nChecks = 0;
        trigTab = '{8'h01, 8'h04, 8'h08, 8'h0E};
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, hresp}, 32'h0, "hresp");
        chk({31'h0, hreadyout}, 32'h1, "hreadyout");
        rdc(IDX_IER, 8'h00, "ier reset");
        rdc(IDX_IIR, 8'h01, "iir reset");
        irqIs(1'b0);
        wr(IDX_IER, 8'hF0);
        rdc(IDX_IER, 8'h00, "ier upper");
        $display("test reset done");
        wr(IDX_IER, 8'h02);
        irqIs(1'b1);
        rdc(IDX_IIR, 8'h02, "thre id");
        rdc(IDX_IIR, 8'h01, "thre read");
        wr(IDX_DATA, 8'hA5);
        txStarted();
        wr(IDX_DATA, 8'h3C);
        peerGot(8'hA5);
        peerGot(8'h3C);
        rdc(IDX_IIR, 8'h02, "thre again");
        $display("test transmit done");
        wr(IDX_LCR, 8'h80);
        @(posedge clk);
        chk({24'h0, lineCtrl}, 32'h80, "line ctrl");
        wr(IDX_DATA, 8'h34);
        wr(IDX_IER, 8'h12);
        @(posedge clk);
        chk({16'h0, divisor}, 32'h1234, "divisor");
        rdc(IDX_DATA, 8'h34, "div low");
        rdc(IDX_IER, 8'h12, "div high");
        rdc(IDX_LCR, 8'h80, "lcr read");
        wr(IDX_LCR, 8'h00);
        rdc(IDX_IER, 8'h02, "ier kept");
        $display("test divisor done");
        wr(IDX_IER, 8'h01);
        for (t = 0; t < 4; t++) begin
            tsel = t[1:0];
            wr(IDX_IIR, {tsel, 6'h01});
            for (k = 1; k < trigTab[t]; k++) recv(8'h40 + 8'(k - 1));
            if (trigTab[t] > 1) rdc(IDX_IIR, 8'hC1, "below trig");
            recv(8'h40 + trigTab[t] - 8'h01);
            rdc(IDX_IIR, 8'hC4, "at trig");
            irqIs(1'b1);
            rdc(IDX_DATA, 8'h40, "rx first");
            rdc(IDX_IIR, 8'hC1, "drop below");
            wr(IDX_IIR, {tsel, 6'h03});
        end
        $display("test trigger done");
        wr(IDX_IIR, 8'h41);
        recv(8'h77);
        repeat (540) @(posedge clk);
        rdc(IDX_IIR, 8'hC1, "no timeout yet");
        repeat (120) @(posedge clk);
        rdc(IDX_IIR, 8'hCC, "timeout");
        rdc(IDX_DATA, 8'h77, "rx timeout");
        rdc(IDX_IIR, 8'hC1, "timeout read");
        $display("test timeout done");
        wr(IDX_IIR, 8'h09);
        wr(IDX_IER, 8'h0F);
        wr(IDX_DATA, 8'h5E);
        peerGot(8'h5E);
        recv(8'h21);
        lineErrEvt <= 1'b1;
        modemChgEvt <= 1'b1;
        @(posedge clk);
        lineErrEvt <= 1'b0;
        modemChgEvt <= 1'b0;
        rdc(IDX_IIR, 8'hC6, "line first");
        irqIs(1'b1);
        rdc(IDX_LSR, 8'h5A, "lsr");
        chk({31'h0, lineStatRd}, 32'h1, "ls pulse");
        rdc(IDX_IIR, 8'hC4, "data second");
        rdc(IDX_DATA, 8'h21, "rx data");
        rdc(IDX_IIR, 8'hC2, "thre third");
        rdc(IDX_IIR, 8'hC0, "modem last");
        rdc(IDX_MSR, 8'h3C, "msr");
        chk({31'h0, modemStatRd}, 32'h1, "ms pulse");
        rdc(IDX_IIR, 8'hC1, "all clear");
        irqIs(1'b0);
        $display("test priority done");
        wr(IDX_IER, 8'h00);
        modemChgEvt <= 1'b1;
        @(posedge clk);
        modemChgEvt <= 1'b0;
        rdc(IDX_IIR, 8'hC1, "inhibited");
        irqIs(1'b0);
        wr(IDX_IER, 8'h08);
        rdc(IDX_IIR, 8'hC0, "modem pend");
        rdc(IDX_MSR, 8'h3C, "msr clear");
        wr(IDX_IER, 8'h01);
        recv(8'h66);
        rdc(IDX_IIR, 8'hC4, "data pend");
        wr(IDX_IIR, 8'h00);
        rdc(IDX_IIR, 8'h01, "fifo off");
        $display("test disable done");
        wr(IDX_IIR, 8'h01);
        wr(IDX_IER, 8'h00);
        wr(IDX_DATA, 8'h81);
        txStarted();
        wr(IDX_DATA, 8'h82);
        wr(IDX_DATA, 8'h83);
        wr(IDX_IIR, 8'h05);
        peerGot(8'h81);
        repeat (400) @(posedge clk);
        chk(ubfi_serial_peer_inst.rxq.size(), 32'h0, "tx cleared");
        $display("test transmit clear done");
        finishTest();
    end
endmodule : test_uart_buffers_fifo_interrupts
`default_nettype wire
